// File: core/rfr_cfg.svh
// Behaviour
// RULE_01: 16 bpp colour bypasses the lookup table
// RULE_02: Rotate refresh by 90, 180, 270 degrees
// RULE_03: Host buffer accesses use untranslated addresses
// RULE_04: System keeps memory clock over 1.25x pixel
// RULE_05: Mode bits 17:16 select rotation
// RULE_06: Code 00 refreshes stored order unrotated
// RULE_07: 90: columns top-down, advancing right to left
// RULE_08: 180: lines right-left, rows bottom to top
// RULE_09: 270: columns bottom-up, advancing left to right
// RULE_10: Frame starts at start address register
// RULE_11: Software computes 90 degree start word
// RULE_12: Software computes 180 degree start word
// RULE_13: Software computes 270 degree start word
// RULE_14: Line offset in words steps each line
`ifndef RFR_CFG_SVH
`define RFR_CFG_SVH
`define RFR_OFS_MODE 8'h10
`define RFR_OFS_START 8'h40
`define RFR_OFS_LINE 8'h44
`define RFR_OFS_GEOM 8'h48
`define RFR_OFS_CTRL 8'h4C
`define RFR_ROT_MSB 17
`define RFR_ROT_LSB 16
`define RFR_DEPTH_MSB 4
`define RFR_DEPTH_LSB 0
`define RFR_START_MSB 16
`define RFR_LINE_MSB 9
`define RFR_GEOM_W_MSB 9
`define RFR_GEOM_H_LSB 16
`define RFR_GEOM_H_MSB 25
`define RFR_CTRL_EN 0
`define RFR_CTRL_BUSY 1
`define RFR_DEPTH_16 5'h10
`define RFR_RST_WORD 32'h00000000
`define RFR_FIFO_DEPTH 8
`define RFR_PIX_W 17
`endif

// File: core/rfr_pkg.sv
`default_nettype none
package rfr_pkg;
	typedef enum logic [1:0] {ROT_0 = 2'b00, ROT_90 = 2'b01, ROT_180 = 2'b10, ROT_270 = 2'b11} rfr_rot_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READ = 2'b01, ST_WAIT = 2'b10, ST_PUSH = 2'b11} rfr_state_t;
	typedef logic [18:0] rfr_byte_addr_t;
endpackage
`default_nettype wire

// File: core/rfr_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rfr_stream_if #(parameter int W = 17);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/rfr_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module rfr_fifo #(parameter int W = 17, parameter int DEPTH = 8) (
	input wire logic clock,
	input wire logic reset_n,
	rfr_stream_if.snk inPort,
	rfr_stream_if.src outPort
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} rfr_fifo_state_t;
	rfr_fifo_state_t s_q, s_d;
	logic push, pop;
	// Full and empty from the occupancy count
	assign inPort.ready = s_q.count < (AW+1)'(DEPTH);
	assign outPort.valid = s_q.count != '0;
	assign outPort.data = s_q.mem[s_q.rdPtr];
	assign push = inPort.valid && inPort.ready;
	assign pop = outPort.valid && outPort.ready;
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wrPtr] = inPort.data;
			s_d.wrPtr = s_q.wrPtr + 1'b1;
		end
		if (pop) begin
			s_d.rdPtr = s_q.rdPtr + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// File: core/rfr_pixel_map.sv
`timescale 1ns/1ns
`default_nettype none
module rfr_pixel_map (
	input wire logic [31:0] word,
	input wire logic [1:0] lane,
	input wire logic depth16,
	output logic [16:0] pixel
);
	always_comb begin
		if (depth16) begin
			// Colour goes straight to the panel, no table lookup [RULE_01]
			pixel = {1'b1, lane[1] ? word[31:16] : word[15:0]};
		end else begin
			pixel = {1'b0, 8'h00, word[{lane, 3'b000} +: 8]};
		end
	end
endmodule
`default_nettype wire

// File: core/rfr_refresh.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rfr_cfg.svh"
module rfr_refresh (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRData,
	input wire logic [16:0] hostAddr,
	input wire logic [31:0] hostWData,
	input wire logic hostWr,
	input wire logic hostRd,
	output logic [16:0] bufAddr,
	output logic [31:0] bufWData,
	output logic bufWr,
	output logic bufRd,
	output logic memRdReq,
	output logic [16:0] memAddr,
	input wire logic [31:0] memRdData,
	input wire logic memRdValid,
	output logic pixValid,
	output logic [15:0] pixData,
	output logic pixDirect,
	input wire logic pixReady
);
	typedef struct packed {
		rfr_pkg::rfr_state_t state;
		rfr_pkg::rfr_rot_t rot;
		logic [4:0] depth;
		logic [16:0] start;
		logic [9:0] lineOfs;
		logic [9:0] width;
		logic [9:0] height;
		logic enable;
		logic [9:0] pixCnt;
		logic [9:0] lineCnt;
		rfr_pkg::rfr_byte_addr_t pixAddr;
		rfr_pkg::rfr_byte_addr_t lineBase;
		logic [31:0] word;
		logic [31:0] rdData;
		logic memRdReq;
		logic [16:0] memAddr;
		logic [16:0] bufAddr;
		logic [31:0] bufWData;
		logic bufWr;
		logic bufRd;
		logic pixValid;
		logic [16:0] pix;
	} rfr_refresh_state_t;

	rfr_refresh_state_t s_q, s_d;
	rfr_stream_if #(.W(`RFR_PIX_W)) fifoIn();
	rfr_stream_if #(.W(`RFR_PIX_W)) fifoOut();
	logic depth16;
	logic lineEnd;
	logic frameEnd;
	logic pushAdv;
	logic frameGo;
	logic [16:0] mapPix;
	rfr_pkg::rfr_byte_addr_t bpb;
	rfr_pkg::rfr_byte_addr_t stride;
	rfr_pkg::rfr_byte_addr_t pixStep;
	rfr_pkg::rfr_byte_addr_t lineStep;
	rfr_pkg::rfr_byte_addr_t startByte;

	// Address step along a display line for one rotation
	function automatic rfr_pkg::rfr_byte_addr_t stepFor(input rfr_pkg::rfr_rot_t rot,
		input rfr_pkg::rfr_byte_addr_t bytes, input rfr_pkg::rfr_byte_addr_t words);
		case (rot)
			rfr_pkg::ROT_0: stepFor = bytes; // [RULE_06]
			rfr_pkg::ROT_90: stepFor = words; // [RULE_02] [RULE_07]
			rfr_pkg::ROT_180: stepFor = rfr_pkg::rfr_byte_addr_t'(19'h00000 - bytes); // [RULE_08]
			rfr_pkg::ROT_270: stepFor = rfr_pkg::rfr_byte_addr_t'(19'h00000 - words); // [RULE_09]
			default: stepFor = bytes;
		endcase
	endfunction

	assign depth16 = s_q.depth == `RFR_DEPTH_16;
	assign bpb = depth16 ? 19'h00002 : 19'h00001;
	// Line offset counts 32-bit words [RULE_14]
	assign stride = {7'h00, s_q.lineOfs, 2'b00};
	assign pixStep = stepFor(s_q.rot, bpb, stride);
	// The line step is the pixel step of the next rotation
	assign lineStep = stepFor(rfr_pkg::rfr_rot_t'(s_q.rot + 2'b01), bpb, stride);
	// 90 and 180 begin at the last pixel of the start word
	assign startByte = (s_q.rot == rfr_pkg::ROT_90 || s_q.rot == rfr_pkg::ROT_180) ?
		rfr_pkg::rfr_byte_addr_t'({s_q.start, 2'b00} + 19'h00004 - bpb) : {s_q.start, 2'b00};
	assign lineEnd = s_q.pixCnt == s_q.width - 1'b1;
	assign frameEnd = lineEnd && s_q.lineCnt == s_q.height - 1'b1;
	assign pushAdv = s_q.state == rfr_pkg::ST_PUSH && fifoIn.ready;
	assign frameGo = s_q.state == rfr_pkg::ST_IDLE && s_q.enable;

	rfr_pixel_map u_map (
		.word(s_q.word),
		.lane(s_q.pixAddr[1:0]),
		.depth16(depth16),
		.pixel(mapPix)
	);

	assign fifoIn.valid = s_q.state == rfr_pkg::ST_PUSH;
	assign fifoIn.data = mapPix;
	assign fifoOut.ready = !s_q.pixValid || pixReady;

	rfr_fifo #(.W(`RFR_PIX_W), .DEPTH(`RFR_FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.inPort(fifoIn),
		.outPort(fifoOut)
	);

	always_comb begin
		s_d = s_q;
		s_d.memRdReq = 1'b0;
		s_d.bufWr = 1'b0;
		s_d.bufRd = 1'b0;
		s_d.rdData = `RFR_RST_WORD;
		// Register reads answer in the next cycle
		if (regRd) begin
			case (regAddr)
				`RFR_OFS_MODE: s_d.rdData = {14'h0000, s_q.rot, 11'h000, s_q.depth};
				`RFR_OFS_START: s_d.rdData = {15'h0000, s_q.start};
				`RFR_OFS_LINE: s_d.rdData = {22'h000000, s_q.lineOfs};
				`RFR_OFS_GEOM: s_d.rdData = {6'h00, s_q.height, 6'h00, s_q.width};
				`RFR_OFS_CTRL: s_d.rdData = {6'h00, s_q.lineCnt, 14'h0000,
					s_q.state != rfr_pkg::ST_IDLE, s_q.enable};
				default: s_d.rdData = `RFR_RST_WORD;
			endcase
		end
		if (regWr) begin
			case (regAddr)
				`RFR_OFS_MODE: begin
					s_d.rot = rfr_pkg::rfr_rot_t'(regWData[`RFR_ROT_MSB:`RFR_ROT_LSB]); // [RULE_05]
					s_d.depth = regWData[`RFR_DEPTH_MSB:`RFR_DEPTH_LSB];
				end
				`RFR_OFS_START: s_d.start = regWData[`RFR_START_MSB:0];
				`RFR_OFS_LINE: s_d.lineOfs = regWData[`RFR_LINE_MSB:0]; // [RULE_14]
				`RFR_OFS_GEOM: begin
					s_d.width = regWData[`RFR_GEOM_W_MSB:0];
					s_d.height = regWData[`RFR_GEOM_H_MSB:`RFR_GEOM_H_LSB];
				end
				`RFR_OFS_CTRL: s_d.enable = regWData[`RFR_CTRL_EN];
				default: s_d.enable = s_q.enable;
			endcase
		end
		// Host buffer path passes its address through untouched [RULE_03]
		if (hostWr || hostRd) begin
			s_d.bufAddr = hostAddr;
			s_d.bufWData = hostWData;
			s_d.bufWr = hostWr;
			s_d.bufRd = hostRd;
		end
		case (s_q.state)
			rfr_pkg::ST_IDLE: begin
				if (s_q.enable) begin
					// Every frame restarts at the programmed corner [RULE_10]
					s_d.pixAddr = startByte;
					s_d.lineBase = startByte;
					s_d.pixCnt = 10'h000;
					s_d.lineCnt = 10'h000;
					s_d.state = rfr_pkg::ST_READ;
				end
			end
			rfr_pkg::ST_READ: begin
				s_d.memRdReq = 1'b1;
				s_d.memAddr = s_q.pixAddr[18:2];
				s_d.state = rfr_pkg::ST_WAIT;
			end
			rfr_pkg::ST_WAIT: begin
				if (memRdValid) begin
					s_d.word = memRdData;
					s_d.state = rfr_pkg::ST_PUSH;
				end
			end
			rfr_pkg::ST_PUSH: begin
				if (fifoIn.ready) begin
					s_d.state = rfr_pkg::ST_READ;
					if (frameEnd) begin
						s_d.state = rfr_pkg::ST_IDLE;
					end else if (lineEnd) begin
						// Next display line [RULE_02] [RULE_14]
						s_d.pixCnt = 10'h000;
						s_d.lineCnt = s_q.lineCnt + 1'b1;
						s_d.lineBase = rfr_pkg::rfr_byte_addr_t'(s_q.lineBase + lineStep);
						s_d.pixAddr = rfr_pkg::rfr_byte_addr_t'(s_q.lineBase + lineStep);
					end else begin
						s_d.pixCnt = s_q.pixCnt + 1'b1;
						s_d.pixAddr = rfr_pkg::rfr_byte_addr_t'(s_q.pixAddr + pixStep); // [RULE_02]
					end
				end
			end
			default: s_d.state = rfr_pkg::ST_IDLE;
		endcase
		// Output stage holds a pixel until the panel takes it
		if (fifoOut.valid && fifoOut.ready) begin
			s_d.pixValid = 1'b1;
			s_d.pix = fifoOut.data;
		end else if (pixReady) begin
			s_d.pixValid = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRData = s_q.rdData;
	assign bufAddr = s_q.bufAddr;
	assign bufWData = s_q.bufWData;
	assign bufWr = s_q.bufWr;
	assign bufRd = s_q.bufRd;
	assign memRdReq = s_q.memRdReq;
	assign memAddr = s_q.memAddr;
	assign pixValid = s_q.pixValid;
	assign pixData = s_q.pix[15:0];
	assign pixDirect = s_q.pix[16];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	chk_direct_colour: assert property (pushAdv && depth16 |-> fifoIn.data[16]) // [RULE_01]
		else $error("16 bpp pixel not marked direct");
	chk_host_untranslated: assert property (hostWr |=> bufWr && bufAddr == $past(hostAddr)) // [RULE_03]
		else $error("host address altered");
	chk_rot_field: assert property (regWr && regAddr == `RFR_OFS_MODE |=> s_q.rot == $past(regWData[17:16])) // [RULE_05]
		else $error("rotation field not stored");
	chk_step_rot0: assert property (pushAdv && !lineEnd && s_q.rot == rfr_pkg::ROT_0 // [RULE_06]
		|=> s_q.pixAddr == rfr_pkg::rfr_byte_addr_t'($past(s_q.pixAddr) + $past(bpb)))
		else $error("unrotated step wrong");
	chk_step_rot90: assert property (pushAdv && !lineEnd && s_q.rot == rfr_pkg::ROT_90 // [RULE_07]
		|=> s_q.pixAddr == rfr_pkg::rfr_byte_addr_t'($past(s_q.pixAddr) + $past(stride)))
		else $error("90 degree step wrong");
	chk_step_rot180: assert property (pushAdv && !lineEnd && s_q.rot == rfr_pkg::ROT_180 // [RULE_08]
		|=> s_q.pixAddr == rfr_pkg::rfr_byte_addr_t'($past(s_q.pixAddr) - $past(bpb)))
		else $error("180 degree step wrong");
	chk_step_rot270: assert property (pushAdv && !lineEnd && s_q.rot == rfr_pkg::ROT_270 // [RULE_09]
		|=> s_q.pixAddr == rfr_pkg::rfr_byte_addr_t'($past(s_q.pixAddr) - $past(stride)))
		else $error("270 degree step wrong");
	chk_frame_start: assert property (frameGo |=> s_q.pixAddr == $past(startByte) ##1 // [RULE_10]
		memRdReq && memAddr == $past(startByte[18:2], 2))
		else $error("frame not started at start address");
	chk_line_stride: assert property (pushAdv && lineEnd && !frameEnd && s_q.rot == rfr_pkg::ROT_0 // [RULE_14]
		|=> s_q.lineBase == rfr_pkg::rfr_byte_addr_t'($past(s_q.lineBase) + $past(stride)))
		else $error("line offset step wrong");
	chk_line_rot90: assert property (pushAdv && lineEnd && !frameEnd && s_q.rot == rfr_pkg::ROT_90 // [RULE_07]
		|=> s_q.lineBase == rfr_pkg::rfr_byte_addr_t'($past(s_q.lineBase) - $past(bpb)))
		else $error("90 degree line step wrong");
	chk_line_rot180: assert property (pushAdv && lineEnd && !frameEnd && s_q.rot == rfr_pkg::ROT_180 // [RULE_08]
		|=> s_q.lineBase == rfr_pkg::rfr_byte_addr_t'($past(s_q.lineBase) - $past(stride)))
		else $error("180 degree line step wrong");
	chk_line_rot270: assert property (pushAdv && lineEnd && !frameEnd && s_q.rot == rfr_pkg::ROT_270 // [RULE_09]
		|=> s_q.lineBase == rfr_pkg::rfr_byte_addr_t'($past(s_q.lineBase) + $past(bpb)))
		else $error("270 degree line step wrong");

	// Corner pixel of the first fetch
	chk_start_rot0: assert property (frameGo && s_q.rot == rfr_pkg::ROT_0 // [RULE_06]
		|=> s_q.pixAddr == {$past(s_q.start), 2'b00})
		else $error("unrotated frame start wrong");
	chk_start_rot90: assert property (frameGo && s_q.rot == rfr_pkg::ROT_90 // [RULE_07]
		|=> s_q.pixAddr == {$past(s_q.start), ($past(depth16) ? 2'b10 : 2'b11)})
		else $error("90 degree frame start wrong");
	chk_start_rot180: assert property (frameGo && s_q.rot == rfr_pkg::ROT_180 // [RULE_08]
		|=> s_q.pixAddr == {$past(s_q.start), ($past(depth16) ? 2'b10 : 2'b11)})
		else $error("180 degree frame start wrong");
	chk_start_rot270: assert property (frameGo && s_q.rot == rfr_pkg::ROT_270 // [RULE_09]
		|=> s_q.pixAddr == {$past(s_q.start), 2'b00})
		else $error("270 degree frame start wrong");

	// Register and host ports
	chk_rdata_idle: assert property (!regRd |=> regRData == 32'h00000000) // [RULE_05]
		else $error("read data not cleared");
	chk_line_reg: assert property (regWr && regAddr == `RFR_OFS_LINE // [RULE_14]
		|=> s_q.lineOfs == $past(regWData[`RFR_LINE_MSB:0]))
		else $error("line offset not stored");
	chk_host_read: assert property (hostRd |=> bufRd && bufAddr == $past(hostAddr)) // [RULE_03]
		else $error("host read address altered");

	// Refresh fetch and pixel stream
	chk_one_read: assert property (memRdReq |=> !memRdReq) // [RULE_02]
		else $error("back to back refresh reads");
	chk_read_addr: assert property (memRdReq |-> memAddr == s_q.pixAddr[18:2]) // [RULE_03]
		else $error("refresh word address wrong");
	chk_frame_done: assert property (pushAdv && frameEnd |=> s_q.state == rfr_pkg::ST_IDLE) // [RULE_10]
		else $error("frame did not end");
	chk_idle_hold: assert property (s_q.state == rfr_pkg::ST_IDLE && !s_q.enable // [RULE_10]
		|=> s_q.state == rfr_pkg::ST_IDLE)
		else $error("refresh started while disabled");
	chk_index_8bpp: assert property (pushAdv && !depth16 |-> fifoIn.data[16:8] == 9'h000) // [RULE_01]
		else $error("8 bpp pixel not a table index");
	chk_pix_hold: assert property (pixValid && !pixReady // [RULE_01]
		|=> pixValid && $stable(pixData) && $stable(pixDirect))
		else $error("pixel dropped before taken");

	cov_frame_0: cover property (pushAdv && frameEnd && s_q.rot == rfr_pkg::ROT_0);
	cov_frame_180: cover property (pushAdv && frameEnd && s_q.rot == rfr_pkg::ROT_180);
	cov_frame_90: cover property (pushAdv && frameEnd && s_q.rot == rfr_pkg::ROT_90);
	cov_frame_270: cover property (pushAdv && frameEnd && s_q.rot == rfr_pkg::ROT_270);
	cov_fifo_full: cover property (s_q.state == rfr_pkg::ST_PUSH && !fifoIn.ready);
endmodule
`default_nettype wire

// File: dv/rfr_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module rfr_mem_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic bufWr,
	input wire logic [16:0] bufAddr,
	input wire logic [31:0] bufWData,
	input wire logic memRdReq,
	input wire logic [16:0] memAddr,
	output logic [31:0] memRdData,
	output logic memRdValid
);
	// Clock ratio is the system's duty; one clock here
	logic [31:0] mem [0:31];
	logic [16:0] addrQ;
	logic slowQ;
	int cnt;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			memRdValid <= 1'b0;
			memRdData <= 32'h0;
			cnt <= 0;
			slowQ <= 1'b0;
		end else begin
			if (bufWr) mem[bufAddr[4:0]] <= bufWData;
			memRdValid <= 1'b0;
			memRdData <= ~memRdData;
			if (memRdReq) begin
				addrQ <= memAddr;
				cnt <= slowQ ? 3 : 1;
				slowQ <= ~slowQ;
			end else if (cnt == 1) begin
				memRdValid <= 1'b1;
				memRdData <= mem[addrQ[4:0]];
				cnt <= 0;
			end else if (cnt > 1) cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// File: dv/rotated_refresh_addressing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rotated_refresh_addressing_tb;
	typedef struct {rfr_pkg::rfr_rot_t rot; logic d16; logic [16:0] start;
		int w; int l; int first; int ps; int ls;} rfr_row_t;
	logic clock, reset_n, regWr, regRd, hostWr, hostRd, pixReady, bufWr, bufRd, memRdReq, memRdValid, pixValid, pixDirect;
	logic [7:0] regAddr;
	logic [31:0] regWData, regRData, hostWData, bufWData, memRdData, s;
	logic [16:0] hostAddr, bufAddr, memAddr;
	logic [15:0] pixData;
	int errTotal, totalChecks;
	// Start words from software formulas
	rfr_row_t rows [8] = '{'{rfr_pkg::ROT_0, 0, 0, 8, 4, 0, 1, 8}, '{rfr_pkg::ROT_90, 0, 1, 4, 8, 7, 8, -1},
		'{rfr_pkg::ROT_180, 0, 7, 8, 4, 31, -1, -8}, '{rfr_pkg::ROT_270, 0, 6, 4, 8, 24, -8, 1},
		'{rfr_pkg::ROT_0, 1, 0, 4, 4, 0, 2, 8}, '{rfr_pkg::ROT_180, 1, 7, 4, 4, 30, -2, -8},
		'{rfr_pkg::ROT_90, 1, 1, 4, 4, 6, 8, -2}, '{rfr_pkg::ROT_270, 1, 6, 4, 4, 24, -8, 2}};
	logic [7:0] offs [6] = '{8'h10, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h20};
	rfr_refresh rfr_refresh_i (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWData(regWData),
		.regWr(regWr), .regRd(regRd), .regRData(regRData), .hostAddr(hostAddr), .hostWData(hostWData),
		.hostWr(hostWr), .hostRd(hostRd), .bufAddr(bufAddr), .bufWData(bufWData), .bufWr(bufWr), .bufRd(bufRd),
		.memRdReq(memRdReq), .memAddr(memAddr), .memRdData(memRdData), .memRdValid(memRdValid),
		.pixValid(pixValid), .pixData(pixData), .pixDirect(pixDirect), .pixReady(pixReady));
	rfr_mem_model rfr_mem_model_i (.clock(clock), .reset_n(reset_n), .bufWr(bufWr), .bufAddr(bufAddr),
		.bufWData(bufWData), .memRdReq(memRdReq), .memAddr(memAddr), .memRdData(memRdData), .memRdValid(memRdValid));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 d = regRData;
	endtask
	task automatic hostWrite(input logic [16:0] a, input logic [31:0] d);
		@(posedge clock);
		hostAddr <= a;
		hostWData <= d;
		hostWr <= 1'b1;
		@(posedge clock);
		hostWr <= 1'b0;
		#1 check("hostAddr", {14'h0, bufWr, bufAddr}, {14'h0, 1'b1, a});
		check("hostData", bufWData, d);
	endtask
	task automatic runRow(input rfr_row_t r);
		int got, g, a;
		logic v, off, dir;
		logic [15:0] d, e;
		got = 0;
		off = 0;
		v = 0;
		d = 0;
		dir = 0;
		regWrite(8'h10, {14'h0, r.rot, 11'h0, r.d16 ? 5'h10 : 5'h08});
		regWrite(8'h40, {15'h0, r.start});
		regWrite(8'h44, 32'h2);
		regWrite(8'h48, {6'h0, 10'(r.l), 6'h0, 10'(r.w)});
		regWrite(8'h4C, 32'h1);
		for (g = 0; g < 3000 && got < r.w * r.l; g++) begin
			@(posedge clock);
			if (v === 1'b1 && pixReady === 1'b1) begin
				a = r.first + (got % r.w) * r.ps + (got / r.w) * r.ls;
				e = r.d16 ? {8'(a + 1), 8'(a)} : {8'h0, 8'(a)};
				check("pixel", {15'h0, dir, d}, {15'h0, r.d16, e});
				got++;
			end
			regAddr <= 8'h4C;
			regWData <= 32'h0;
			regWr <= (got == 1 && !off);
			if (got == 1) off = 1'b1;
			// Long stall fills the pixel FIFO
			pixReady <= (g % 4 != 3) && (g < 20 || g >= 120);
			#1 v = pixValid;
			d = pixData;
			dir = pixDirect;
		end
		check("count", 32'(got), 32'(r.w * r.l));
		s = 32'h2;
		for (g = 0; g < 50 && s[1]; g++) regRead(8'h4C, s);
		check("idle", {30'h0, s[1], pixValid}, 32'h0);
	endtask
	initial begin
		errTotal = 0;
		totalChecks = 0;
		reset_n = 1'b0;
		{regWr, regRd, hostWr, hostRd, pixReady} = 5'h00;
		regAddr = 8'h00;
		regWData = 32'h0;
		hostAddr = 17'h0;
		hostWData = 32'h0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		foreach (offs[i]) begin
			regRead(offs[i], s);
			check("reset", s, 32'h0);
		end
		regWrite(8'h10, 32'hFFFFFFFF);
		regRead(8'h10, s);
		check("mode", s, 32'h0003001F);
		regWrite(8'h20, 32'hFFFFFFFF);
		regRead(8'h20, s);
		check("unmapped", s, 32'h0);
		for (int w = 0; w < 32; w++) hostWrite(17'(w), {8'(4 * w + 3), 8'(4 * w + 2), 8'(4 * w + 1), 8'(4 * w)});
		@(posedge clock);
		hostAddr <= 17'h5;
		hostRd <= 1'b1;
		@(posedge clock);
		hostRd <= 1'b0;
		#1 check("hostRd", {bufRd, bufWr, 13'h0, bufAddr}, {2'b10, 13'h0, 17'h5});
		foreach (rows[i]) runRow(rows[i]);
		// Reset in mid-frame clears state and outputs
		regWrite(8'h4C, 32'h1);
		repeat (20) @(posedge clock);
		reset_n <= 1'b0;
		#1 check("midReset", {28'h0, pixValid, memRdReq, bufWr, bufRd}, 32'h0);
		check("midResetAddr", {15'h0, memAddr}, 32'h0);
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		regRead(8'h4C, s);
		check("ctrlAfterReset", s, 32'h0);
		regRead(8'h10, s);
		check("modeAfterReset", s, 32'h0);
		runRow(rows[2]);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clock);
		errTotal++;
		summarize();
	end
endmodule
`default_nettype wire
